// ===== src/rpc_params.svh
// constants for the repeater control-pin sequencer and its register map
// Behaviour
// RL1: power-down low forces every channel off whatever the other pins do.
// RL2: restart low holds the detect machine reset, terminations high impedance.
// RL3: pair enable low skips detection; receive terminations go to 50 ohm.
// RL4: pair enable high gives 50 ohm only after a far receiver is found.
// RL5: no receiver found squelches the output and keeps high impedance.
// RL6: idle channel with a receiver squelches but keeps common mode and 50 ohm.
// RL7: enabled, detected and not idle drives the output actively.
// RL8: one enable governs channels A0 and A1, the other B0 and B1.
// RL9: detection is requested by a restart low pulse of at least 200 ns.
// RL10: detection starts on the rising edge of the restart pin.
// RL11: pair enables stable from 200 ns before rise to 2 ms after.
// RL12: exactly one detection pass per restart low pulse.
// RL13: weak input envelope puts the channel into electrical idle.
// RL14: route low multicasts, open connects directly, high cross-connects.
// RL15: for mux functions the route pin moves only between high and open.
// RL16: no receiver on either channel of a pair sets both to high impedance.
// RL17: a floating route pin settles mid level, giving direct connect.
// RL18: each pair's detect result is held until the next restart or power-down.
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define RPC_CLK_MHZ       100
`define RPC_PULSE_NS      200
`define RPC_SETUP_NS      200
`define RPC_HOLD_US       2000
`define RPC_PULSE_CYC     ((`RPC_PULSE_NS * `RPC_CLK_MHZ + 999) / 1000)
`define RPC_SETUP_CYC     ((`RPC_SETUP_NS * `RPC_CLK_MHZ + 999) / 1000)
`define RPC_HOLD_CYC      (`RPC_HOLD_US * `RPC_CLK_MHZ)

// ----------------------------------------
// register map
// ----------------------------------------
`define RPC_ADDR_W        4
`define RPC_OFF_CTRL      4'h0
`define RPC_OFF_CMD       4'h4
`define RPC_OFF_STATUS    4'h8
`define RPC_RESP_OKAY     2'h0
`define RPC_RESP_SLVERR   2'h2
`define RPC_CTRL_LOCK     0
`define RPC_ST_BUSY       0
`define RPC_ST_ROOM       1
`define RPC_ST_REFUSED    2
`define RPC_ST_RESTART    3
`define RPC_ST_PWR        4
`define RPC_ST_EN_A       5
`define RPC_ST_EN_B       6
`define RPC_ST_CNT_LSB    8
`define RPC_BUF_DEPTH     2

// ----------------------------------------
// route select field codes
// ----------------------------------------
`define RPC_ROUTE_MCAST   2'h0
`define RPC_ROUTE_DIRECT  2'h1
`define RPC_ROUTE_CROSS   2'h2

`endif

// ===== src/rpc_pkg.sv
// types shared by the repeater control-pin sequencer
package rpc_pkg;
	// one queued order: bit 0 detect, 2:1 route, 3 pair a, 4 pair b, 5 power on
	typedef struct packed {
		logic       powerdown_n;
		logic       pair_b;
		logic       pair_a;
		logic [1:0] route;
		logic       detect;
	} rpc_cmd_t;

	typedef enum logic [1:0] {
		RPC_SEQ_IDLE,
		RPC_SEQ_PULSE,
		RPC_SEQ_HOLD
	} rpc_seq_t;
endpackage

// ===== src/rpc_buf.sv
// two-entry valid/ready buffer for queued orders
`timescale 1ns/10ps
module rpc_buf #(
	parameter int unsigned W     = 6,
	parameter int unsigned DEPTH = 2
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// fill side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// drain side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wr_ptr;
		logic [PW-1:0]           rd_ptr;
		logic [PW:0]             count;
	} rpc_buf_st_t;

	rpc_buf_st_t s;
	rpc_buf_st_t n;
	logic        push;
	logic        pop;

	// honest flags straight from the occupancy count
	assign in_ready  = (s.count != (PW+1)'(DEPTH));
	assign out_valid = (s.count != '0);
	assign out_data  = s.mem[s.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer and storage update
	always_comb begin
		n = s;
		for (int i = 0; i < DEPTH; i++) begin
			if (push && (s.wr_ptr == PW'(i))) begin
				n.mem[i] = in_data;
			end
		end
		if (push) begin
			n.wr_ptr = (s.wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(s.wr_ptr + 1'b1);
		end
		if (pop) begin
			n.rd_ptr = (s.rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(s.rd_ptr + 1'b1);
		end
		n.count = (PW+1)'(s.count + (PW+1)'(push) - (PW+1)'(pop));
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule

// ===== src/rpc_timer.sv
// loadable down-counter used to time pin phases
`timescale 1ns/10ps
module rpc_timer #(
	parameter int unsigned W = 18
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// load and status
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              done
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} rpc_timer_st_t;

	rpc_timer_st_t s;
	rpc_timer_st_t n;

	assign done = (s.cnt == '0);

	// load wins over counting down
	always_comb begin
		n = s;
		if (load) begin
			n.cnt = value;
		end else if (s.cnt != '0) begin
			n.cnt = W'(s.cnt - 1'b1);
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule

// ===== src/rpc_ctl_top.sv
// axi4-lite controlled sequencer for the repeater control pins
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "rpc_params.svh"
module rpc_ctl_top #(
	parameter int unsigned HOLD_CYCLES = `RPC_HOLD_CYC
) (
	// clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// axi4-lite write address
	input  wire logic [`RPC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// axi4-lite read address
	input  wire logic [`RPC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// repeater control pins
	output logic                        full_powerdown_n,
	output logic                        detect_restart_n,
	output logic                        pair_a_detect_enable,
	output logic                        pair_b_detect_enable,
	output logic                        route_select_out,
	output logic                        route_select_oe
);
	localparam int unsigned AW      = `RPC_ADDR_W;
	localparam int unsigned TW      = $clog2(HOLD_CYCLES + 1);
	localparam int unsigned CW      = $bits(rpc_pkg::rpc_cmd_t);
	localparam int unsigned LOW_CYC = (`RPC_PULSE_CYC > `RPC_SETUP_CYC) ? `RPC_PULSE_CYC : `RPC_SETUP_CYC;

	typedef struct packed {
		rpc_pkg::rpc_seq_t seq;
		logic              aw_have;
		logic [AW-1:0]     aw_addr;
		logic              w_have;
		logic [7:0]        w_data;
		logic              w_strb0;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              mux_lock;
		logic              refused;
		logic [7:0]        pass_cnt;
		rpc_pkg::rpc_cmd_t last_cmd;
		logic              pd_n;
		logic              restart_n;
		logic              en_a;
		logic              en_b;
		logic              rs_out;
		logic              rs_oe;
	} rpc_main_st_t;

	rpc_main_st_t      s;
	rpc_main_st_t      n;
	rpc_pkg::rpc_cmd_t cmd;
	rpc_pkg::rpc_cmd_t buf_out_data;
	logic              buf_in_valid;
	logic              buf_in_ready;
	logic              buf_out_valid;
	logic              buf_out_ready;
	logic              timer_load;
	logic [TW-1:0]     timer_val;
	logic              timer_done;
	logic              wr_go;
	logic              wr_done;
	logic              clear_ref;
	logic              set_ref;
	logic [AW-1:0]     wa;
	logic [AW-1:0]     ra;

	// ----------------------------------------
	// order queue and phase timer
	// ----------------------------------------
	rpc_buf #(
		.W     (CW),
		.DEPTH (`RPC_BUF_DEPTH)
	) u_buf (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (buf_in_valid),
		.in_data   (s.w_data[CW-1:0]),
		.in_ready  (buf_in_ready),
		.out_valid (buf_out_valid),
		.out_data  (buf_out_data),
		.out_ready (buf_out_ready)
	);

	rpc_timer #(
		.W (TW)
	) u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.load    (timer_load),
		.value   (timer_val),
		.done    (timer_done)
	);

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		n             = s;
		cmd           = buf_out_data;
		buf_in_valid  = 1'b0;
		buf_out_ready = 1'b0;
		timer_load    = 1'b0;
		timer_val     = '0;
		wr_done       = 1'b0;
		clear_ref     = 1'b0;
		set_ref       = 1'b0;
		wa            = {s.aw_addr[AW-1:2], 2'b00};
		ra            = {s_axi_araddr[AW-1:2], 2'b00};
		wr_go         = s.aw_have && s.w_have && !s.bvalid;
		// address and data are taken independently
		if (s_axi_awvalid && s.awready) begin
			n.aw_have = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			n.w_have  = 1'b1;
			n.w_data  = s_axi_wdata[7:0];
			n.w_strb0 = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		// register write; an order waits here while the queue is full
		n.bresp = s.bresp;
		if (wr_go) begin
			wr_done = 1'b1;
			n.bresp = `RPC_RESP_OKAY;
			if (wa == `RPC_OFF_CTRL) begin
				if (s.w_strb0) begin
					n.mux_lock = s.w_data[`RPC_CTRL_LOCK];
				end
			end else if (wa == `RPC_OFF_CMD) begin
				buf_in_valid = s.w_strb0;
				wr_done      = !s.w_strb0 || buf_in_ready;
			end else if (wa == `RPC_OFF_STATUS) begin
				clear_ref = s.w_strb0 && s.w_data[`RPC_ST_REFUSED];
			end else begin
				n.bresp = `RPC_RESP_SLVERR;
			end
			if (wr_done) begin
				n.aw_have = 1'b0;
				n.w_have  = 1'b0;
				n.bvalid  = 1'b1;
			end
		end
		// register read
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arready) begin
			n.rvalid = 1'b1;
			n.rdata  = '0;
			n.rresp  = `RPC_RESP_OKAY;
			if (ra == `RPC_OFF_CTRL) begin
				n.rdata[`RPC_CTRL_LOCK] = s.mux_lock;
			end else if (ra == `RPC_OFF_CMD) begin
				n.rdata[CW-1:0] = s.last_cmd;
			end else if (ra == `RPC_OFF_STATUS) begin
				n.rdata[`RPC_ST_BUSY]                       = (s.seq != rpc_pkg::RPC_SEQ_IDLE);
				n.rdata[`RPC_ST_ROOM]                       = buf_in_ready;
				n.rdata[`RPC_ST_REFUSED]                    = s.refused;
				n.rdata[`RPC_ST_RESTART]                    = s.restart_n;
				n.rdata[`RPC_ST_PWR]                        = s.pd_n;
				n.rdata[`RPC_ST_EN_A]                       = s.en_a;
				n.rdata[`RPC_ST_EN_B]                       = s.en_b;
				n.rdata[`RPC_ST_CNT_LSB+7:`RPC_ST_CNT_LSB] = s.pass_cnt;
			end else begin
				n.rresp = `RPC_RESP_SLVERR;
			end
		end
		// pin sequencer: orders are applied only between detection passes
		unique case (s.seq)
			rpc_pkg::RPC_SEQ_IDLE: begin
				if (buf_out_valid) begin
					buf_out_ready = 1'b1;
					n.last_cmd    = cmd;
					n.pd_n        = cmd.powerdown_n;      // [RL1] [RL2]
					n.en_a        = cmd.pair_a;           // [RL8]
					n.en_b        = cmd.pair_b;           // [RL8]
					if (s.mux_lock && (cmd.route == `RPC_ROUTE_MCAST)) begin
						set_ref = 1'b1;                   // [RL15]
					end else if (cmd.route == `RPC_ROUTE_MCAST) begin
						n.rs_out = 1'b0;                  // [RL14]
						n.rs_oe  = 1'b1;
					end else if (cmd.route == `RPC_ROUTE_CROSS) begin
						n.rs_out = 1'b1;                  // [RL14] [RL15]
						n.rs_oe  = 1'b1;
					end else begin
						n.rs_out = 1'b0;                  // [RL17] released pin floats mid level
						n.rs_oe  = 1'b0;
					end
					if (cmd.detect && cmd.powerdown_n) begin
						n.restart_n = 1'b0;               // [RL9]
						timer_load  = 1'b1;
						timer_val   = TW'(LOW_CYC - 1);
						n.seq       = rpc_pkg::RPC_SEQ_PULSE;
					end
				end
			end
			rpc_pkg::RPC_SEQ_PULSE: begin
				if (timer_done) begin
					n.restart_n = 1'b1;                   // [RL10] [RL12]
					timer_load  = 1'b1;
					timer_val   = TW'(HOLD_CYCLES - 1);
					n.seq       = rpc_pkg::RPC_SEQ_HOLD;
				end
			end
			rpc_pkg::RPC_SEQ_HOLD: begin
				if (timer_done) begin                     // [RL11]
					n.pass_cnt = 8'(s.pass_cnt + 1'b1);
					n.seq      = rpc_pkg::RPC_SEQ_IDLE;
				end
			end
		endcase
		// a refusal in the clearing cycle is kept
		n.refused = (s.refused && !clear_ref) || set_ref;
		n.awready = !n.aw_have && !n.bvalid;
		n.wready  = !n.w_have && !n.bvalid;
		n.arready = !n.rvalid;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s           <= '0;
			s.seq       <= rpc_pkg::RPC_SEQ_IDLE;
			s.restart_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// outputs straight from the state register
	assign s_axi_awready        = s.awready;
	assign s_axi_wready         = s.wready;
	assign s_axi_bresp          = s.bresp;
	assign s_axi_bvalid         = s.bvalid;
	assign s_axi_arready        = s.arready;
	assign s_axi_rdata          = s.rdata;
	assign s_axi_rresp          = s.rresp;
	assign s_axi_rvalid         = s.rvalid;
	assign full_powerdown_n     = s.pd_n;
	assign detect_restart_n     = s.restart_n;
	assign pair_a_detect_enable = s.en_a;
	assign pair_b_detect_enable = s.en_b;
	assign route_select_out     = s.rs_out;
	assign route_select_oe      = s.rs_oe;

	// ----------------------------------------
	// checks on the driven pins
	// ----------------------------------------
	localparam int PULSE_MIN = LOW_CYC;
	logic [TW-1:0] low_cnt;
	logic [TW-1:0] since_rise;
	logic [TW-1:0] since_en;

	// helper counters: low length, cycles since rise, cycles since enable change
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_cnt    <= '0;
			since_rise <= '1;
			since_en   <= '1;
		end else begin
			low_cnt    <= s.restart_n ? '0 : TW'(low_cnt + 1'b1);
			since_rise <= (n.restart_n && !s.restart_n) ? '0 :
				((since_rise == '1) ? since_rise : TW'(since_rise + 1'b1));
			since_en   <= ((n.en_a != s.en_a) || (n.en_b != s.en_b)) ? '0 :
				((since_en == '1) ? since_en : TW'(since_en + 1'b1));
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence restart_fall_s;
		$fell(detect_restart_n);
	endsequence
	sequence restart_low_s;
		!detect_restart_n [*8];
	endsequence
	property pulse_shape_p;
		restart_fall_s |-> restart_low_s;
	endproperty

	pulse_shape_a: assert property (pulse_shape_p) else $error("restart pulse too short"); // [RL9]
	pulse_len_a: assert property ($rose(detect_restart_n) |-> low_cnt == TW'(PULSE_MIN)) // [RL9]
		else $error("restart low length wrong");
	en_setup_a: assert property ($rose(detect_restart_n) |-> since_en >= TW'(`RPC_SETUP_CYC)) // [RL11]
		else $error("pair enable changed too close to restart rise");
	en_hold_a: assert property ($changed({pair_a_detect_enable, pair_b_detect_enable}) // [RL11]
		|-> $past(detect_restart_n) && since_rise >= TW'(HOLD_CYCLES)) else $error("pair enable changed during detection");
	pair_cmd_a: assert property (restart_fall_s |-> pair_a_detect_enable == s.last_cmd.pair_a // [RL8]
		&& pair_b_detect_enable == s.last_cmd.pair_b) else $error("pair enables differ from order");
	route_lock_a: assert property ($changed({route_select_out, route_select_oe}) && $past(s.mux_lock) // [RL15]
		|-> !(route_select_oe && !route_select_out)) else $error("route driven low while locked");
	one_rise_a: assert property ($rose(detect_restart_n) |=> detect_restart_n [*8]) // [RL12]
		else $error("second restart pulse inside hold");
endmodule

// ===== src/rpc_unused_placeholder_none.sv
// intentionally empty file list terminator
`timescale 1ns/10ps

// ===== dv/rpc_rep_model.sv
// behavioural model of the repeater's pin-strapped control logic
`timescale 1ns/10ps
`include "rpc_params.svh"
module rpc_rep_model #(
	parameter int HOLD = 40
) (
	// clock used to time the pins
	input  wire logic       aclk,
	// control pins
	input  wire logic       pd_n,
	input  wire logic       rst_n,
	input  wire logic       en_a,
	input  wire logic       en_b,
	input  wire logic [1:0] route_lvl,
	// far receivers present
	input  wire logic       rx_a,
	input  wire logic       rx_b,
	// input envelope below threshold on every channel
	input  wire logic       idle,
	// observed device state
	output logic            term_a,
	output logic            term_b,
	output logic [1:0]      tx_on,
	output logic [1:0]      mode,
	output logic [7:0]      passes,
	output logic [7:0]      viol
);
	logic [7:0]  low_cnt  = 8'h00;
	logic [7:0]  age      = 8'h00;
	logic [15:0] hold_cnt = 16'h0000;
	logic        rst_q    = 1'b1;
	logic        det_a    = 1'b0;
	logic        det_b    = 1'b0;
	logic [1:0]  en_q     = 2'h0;

	// counters start clear
	initial begin
		passes = 8'h00;
		viol = 8'h00;
	end

	// sample pins on the falling edge, away from the edge that moves them
	always @(negedge aclk) begin
		rst_q <= rst_n;
		en_q <= {en_b, en_a};
		age <= ({en_b, en_a} != en_q) ? 8'h01 : ((age == 8'hff) ? age : age + 8'h01);
		if (pd_n !== 1'b1) begin
			det_a <= 1'b0;
			det_b <= 1'b0;
			low_cnt <= 8'h00;
			hold_cnt <= 16'h0000;
		end else if (rst_n === 1'b0) begin
			low_cnt <= low_cnt + 8'h01;
			det_a <= 1'b0;
			det_b <= 1'b0;
		end else if (!rst_q) begin
			if (low_cnt < 8'd20) viol <= viol + 8'h01;
			if ((en_a || en_b) && age < 8'd20) viol <= viol + 8'h01;
			passes <= passes + 8'h01;
			det_a <= rx_a;
			det_b <= rx_b;
			hold_cnt <= 16'(HOLD - 1);
			low_cnt <= 8'h00;
		end else if (hold_cnt != 16'h0000) begin
			hold_cnt <= hold_cnt - 16'h0001;
			if ({en_b, en_a} != en_q) viol <= viol + 8'h01;
		end
	end

	// 50 ohm once detected or with detection skipped, else high impedance
	assign term_a = pd_n && rst_n && (!en_a || det_a);
	assign term_b = pd_n && rst_n && (!en_b || det_b);
	// output toggles only with 50 ohm set up and a live input; idle keeps the terminations
	assign tx_on = {term_b && !idle, term_a && !idle};
	// three-level route pin: low multicast, high cross, open direct
	assign mode = (route_lvl == 2'h0) ? `RPC_ROUTE_MCAST :
		((route_lvl == 2'h2) ? `RPC_ROUTE_CROSS : `RPC_ROUTE_DIRECT);
endmodule

// ===== dv/repeater_termination_routing_ctl_tb.sv
// self-checking bench for the repeater control-pin sequencer
`timescale 1ns/10ps
`include "rpc_params.svh"
module repeater_termination_routing_ctl_tb;
	localparam int HOLD = 40;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  awaddr = 4'h0;
	logic [3:0]  araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, route_lvl, mode, rsp, tx_on;
	logic [31:0] rdata, rd;
	logic        pd_n, rst_n, en_a, en_b, rs_out, rs_oe, term_a, term_b;
	logic        rx_a = 1'b1;
	logic        rx_b = 1'b1;
	logic        idle = 1'b0;
	logic [7:0]  passes, viol;
	int          failures = 0;
	int          cmp_count = 0;

	// --------
	// design, wire resolution and device model
	// --------
	rpc_ctl_top #(.HOLD_CYCLES(HOLD)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.full_powerdown_n(pd_n), .detect_restart_n(rst_n), .pair_a_detect_enable(en_a),
		.pair_b_detect_enable(en_b), .route_select_out(rs_out), .route_select_oe(rs_oe));
	// released pin floats to mid level
	assign route_lvl = rs_oe ? {rs_out, 1'b0} : 2'h1;
	rpc_rep_model #(.HOLD(HOLD)) model_u (.aclk(aclk), .pd_n(pd_n), .rst_n(rst_n), .en_a(en_a),
		.en_b(en_b), .route_lvl(route_lvl), .rx_a(rx_a), .rx_b(rx_b), .idle(idle), .term_a(term_a),
		.term_b(term_b), .tx_on(tx_on), .mode(mode), .passes(passes), .viol(viol));

	// 100 mhz clock
	initial begin
		forever #5 aclk = ~aclk;
	end

	// --------
	// tasks
	// --------
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// write: both channels offered together, each released once taken
	task axw(input logic [3:0] a, input logic [31:0] d);
		logic ga, gw, gb;
		gb = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!gb) begin
			@(negedge aclk);
			ga = awvalid && awready === 1'b1;
			gw = wvalid && wready === 1'b1;
			gb = bvalid === 1'b1;
			rsp = bresp;
			@(posedge aclk);
			if (ga) awvalid <= 1'b0;
			if (gw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	task axr(input logic [3:0] a);
		logic ga, gr;
		gr = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!gr) begin
			@(negedge aclk);
			ga = arvalid && arready === 1'b1;
			gr = rvalid === 1'b1;
			rd = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ga) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask

	// bounded wait for the model to count a pass, then for busy to clear
	task wait_done(input logic [7:0] n);
		int k;
		k = 0;
		while (passes !== n && k < 1000) begin
			@(negedge aclk);
			k++;
		end
		do begin
			axr(`RPC_OFF_STATUS);
			k++;
		end while (rd[`RPC_ST_BUSY] !== 1'b0 && k < 2000);
		// a pass that never finishes ends the run as a failure
		if (k >= 2000) begin
			failures++;
			test_done;
		end
	endtask

	task test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// --------
	// tests
	// --------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axr(`RPC_OFF_STATUS);
		chk(rd, 32'ha, "status after reset");
		chk(32'(rsp), 32'(`RPC_RESP_OKAY), "status read okay");
		chk(32'(term_a), 0, "rx a off");
		axr(4'hc);
		chk(32'(rsp), 32'(`RPC_RESP_SLVERR), "unmapped");
		chk(rd, 0, "unmapped data");
		axw(4'hc, 32'h1);
		chk(32'(rsp), 32'(`RPC_RESP_SLVERR), "unmapped write");
		$display("test 1 done");
		@(posedge aclk);
		wstrb <= 4'h0;
		axw(`RPC_OFF_CTRL, 32'h1);
		chk(32'(rsp), 32'(`RPC_RESP_OKAY), "masked write okay");
		axr(`RPC_OFF_CTRL);
		chk(rd, 0, "masked write");
		wstrb <= 4'hf;
		axw(`RPC_OFF_CTRL, 32'h1);
		axr(`RPC_OFF_CTRL);
		chk(rd, 1, "lock set");
		axw(`RPC_OFF_CTRL, 32'h0);
		$display("test 2 done");
		axw(`RPC_OFF_CMD, 32'h22);
		repeat (3) @(posedge aclk);
		chk({30'h0, term_b, term_a}, 3, "skip detect 50 ohm");
		chk(32'(mode), 32'(`RPC_ROUTE_DIRECT), "open pin");
		axr(`RPC_OFF_STATUS);
		chk(rd & 32'h7f, 32'h1a, "powered status");
		axr(`RPC_OFF_CMD);
		chk(rd & 32'h3f, 32'h22, "last order");
		$display("test 3 done");
		for (int i = 0; i < 4; i++) begin
			axw(`RPC_OFF_CMD, 32'h20 | (i << 1));
			repeat (3) @(posedge aclk);
			chk(32'(mode), (i == 3) ? 32'(`RPC_ROUTE_DIRECT) : i, "route code");
		end
		axw(`RPC_OFF_CTRL, 32'h1);
		axw(`RPC_OFF_CMD, 32'h24);
		axw(`RPC_OFF_CMD, 32'h20);
		repeat (3) @(posedge aclk);
		chk(32'(mode), 32'(`RPC_ROUTE_CROSS), "locked route kept");
		axr(`RPC_OFF_STATUS);
		chk(32'(rd[`RPC_ST_REFUSED]), 1, "refused set");
		axw(`RPC_OFF_STATUS, 32'h4);
		axr(`RPC_OFF_STATUS);
		chk(32'(rd[`RPC_ST_REFUSED]), 0, "refused cleared");
		axw(`RPC_OFF_CTRL, 32'h0);
		$display("test 4 done");
		axw(`RPC_OFF_CMD, 32'h2b);
		repeat (3) @(posedge aclk);
		chk({30'h0, rst_n, term_a}, 0, "restart held low");
		wait_done(8'd1);
		chk({30'h0, term_b, term_a}, 3, "receiver found");
		chk(32'(tx_on), 3, "active output");
		idle <= 1'b1;
		@(posedge aclk);
		chk(32'(tx_on), 0, "idle squelch");
		chk({30'h0, term_b, term_a}, 3, "idle keeps 50 ohm");
		idle <= 1'b0;
		chk(32'(rd[15:8]), 1, "one pass");
		chk(32'(viol), 0, "pin timing");
		$display("test 5 done");
		rx_a <= 1'b0;
		axw(`RPC_OFF_CMD, 32'h3b);
		axw(`RPC_OFF_CMD, 32'h3b);
		wait_done(8'd3);
		chk(32'(passes), 3, "pass per pulse");
		chk({30'h0, term_b, term_a}, 2, "pair a absent");
		chk(32'(tx_on), 2, "no receiver squelch");
		chk(32'(rd[15:8]), 3, "pass count");
		chk(32'(viol), 0, "pin timing");
		$display("test 6 done");
		axw(`RPC_OFF_CMD, 32'h01);
		repeat (30) @(posedge aclk);
		chk({29'h0, pd_n, rst_n, term_a}, 2, "powered down");
		chk(32'(passes), 3, "no pass when off");
		$display("test 7 done");
		test_done;
	end

	// watchdog
	initial begin
		#100us;
		failures++;
		test_done;
	end
endmodule
